// >>> common/ccpcu_params.svh
// Constants for the capture unit: register offsets, fields, resets, prescaler counts.
`ifndef CCPCU_PARAMS_SVH
`define CCPCU_PARAMS_SVH

// Register byte offsets on the APB bus.
`define CCPCU_OFF_CONTROL 12'h000
`define CCPCU_OFF_VAL_LOW 12'h004
`define CCPCU_OFF_VAL_HIGH 12'h008
`define CCPCU_OFF_FLAG 12'h00C
`define CCPCU_OFF_PINSEL 12'h010

// Field positions of the control register.
`define CCPCU_MODE_LSB 0
`define CCPCU_MODE_MSB 3
`define CCPCU_DUTY_LSB 4
`define CCPCU_DUTY_MSB 5
`define CCPCU_CTRL_MASK 8'h3F

// Reset values.
`define CCPCU_CTRL_RESET 8'h00
`define CCPCU_VAL_RESET 16'h0000

// Prescaler edge counts.
`define CCPCU_PRE_4 5'h04
`define CCPCU_PRE_16 5'h10

`endif

// >>> common/ccpcu_pkg.sv
// Types shared by the capture unit files.
package ccpcu_pkg;
    // Decoded operating mode of the unit.
    typedef enum logic [1:0] {
        CCPCU_OFF,
        CCPCU_CAPTURE,
        CCPCU_COMPARE,
        CCPCU_PWM
    } ccpcu_kind_e;
    // Mode field code.
    typedef logic [3:0] ccpcu_mode_t;
endpackage

// >>> rtl/ccpcu_edge_sync.sv
// Two-stage pin synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
`default_nettype none
module ccpcu_edge_sync (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Raw asynchronous pin level.
    input wire logic pin_async,
    // Edge pulses on the synchronised level.
    output logic rise,
    output logic fall
);
    logic meta; // First stage, read only by the second stage.
    logic sync; // Second stage, safe to use.
    logic last; // Previous synchronised level.
    logic next_meta;
    logic next_sync;
    logic next_last;
    logic next_rise;
    logic next_fall;

    // Edges come from the settled stages only, never from the first one.
    always_comb begin
        next_meta = pin_async;
        next_sync = meta;
        next_last = sync;
        next_rise = sync & ~last;
        next_fall = ~sync & last;
    end

    // Register the synchroniser and edge pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
            rise <= next_rise;
            fall <= next_fall;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/ccpcu_capture_unit.sv
// Capture/compare unit top: APB registers, pin capture, prescaler, actions.
`timescale 1ns/1ps
`default_nettype none
`include "ccpcu_params.svh"
module ccpcu_capture_unit #(
    parameter bit IS_SECOND_UNIT = 1'b1, // Only unit two starts conversions.
    parameter int TW = 16 // Companion timer width.
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Capture pin levels on the two alternative pins, read always.
    input wire logic portc_pin_one,
    input wire logic portb_pin_three,
    // Companion timer count and compare match from the timer.
    input wire logic [TW-1:0] companion_timer_count,
    input wire logic timer_match,
    // Compare pin output, special event trigger, pending timer reset and conversion start.
    output logic compare_out,
    output logic special_trigger,
    output logic timer_reset_req,
    output logic adc_start,
    // Event flag level and 10-bit PWM duty value.
    output logic event_flag,
    output logic [9:0] pwm_duty
);
    import ccpcu_pkg::*;

    logic [7:0] unit_control; // Low six bits live.
    logic [TW-1:0] capture_value; // High and low capture value pair.
    logic pin_select; // Zero picks portc_pin_one, one portb_pin_three.
    logic [4:0] pre_count; // Counts qualifying rising edges.
    logic pin_rise;
    logic pin_fall;
    logic [1:0] pin_lvl; // Bit 0 portc_pin_one, bit 1 portb_pin_three.
    logic [1:0] rise_v; // Edge pulses of each synchronised pin.
    logic [1:0] fall_v;
    logic [7:0] next_control;
    logic [TW-1:0] next_value;
    logic next_pin_select;
    logic [4:0] next_pre_count;
    logic next_flag;
    logic next_compare_out;
    logic next_trigger;
    logic next_timer_reset;
    logic next_adc;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic capture_hit;
    logic mode_write;
    logic setup;
    logic access_wr;
    logic access_rd;
    ccpcu_mode_t mode;

    // Decodes a mode code to its kind; used for datapath and checks.
    function automatic ccpcu_kind_e kind_of(input ccpcu_mode_t m);
        ccpcu_kind_e k;
        k = CCPCU_OFF;
        unique case (m)
            4'h4, 4'h5, 4'h6, 4'h7: k = CCPCU_CAPTURE;
            4'h2, 4'h8, 4'h9, 4'hA, 4'hB: k = CCPCU_COMPARE;
            4'hC, 4'hD, 4'hE, 4'hF: k = CCPCU_PWM;
            default: k = CCPCU_OFF;
        endcase
        return k;
    endfunction

    assign mode = unit_control[`CCPCU_MODE_MSB:`CCPCU_MODE_LSB];
    // Both pins are synchronised first and the choice is made on clean
    // edges, so no logic ever reads a raw asynchronous level.
    assign pin_lvl = {portb_pin_three, portc_pin_one};

    // The pin level is sampled whatever its direction, so port writes count.
    for (genvar g = 0; g < 2; g++) begin : g_sync
        ccpcu_edge_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .pin_async(pin_lvl[g]),
            .rise(rise_v[g]),
            .fall(fall_v[g])
        );
    end

    // Pin chosen by alternate select; unit one always uses the first.
    assign pin_rise = (IS_SECOND_UNIT && pin_select) ?
        rise_v[1] : rise_v[0];
    assign pin_fall = (IS_SECOND_UNIT && pin_select) ?
        fall_v[1] : fall_v[0];

    // APB phases: answer on the first access cycle, no wait states.
    assign setup = psel & ~penable;
    assign access_wr = psel & penable & pwrite & pready;
    assign access_rd = setup & ~pwrite;
    assign mode_write = access_wr && paddr == `CCPCU_OFF_CONTROL;

    // Capture event and prescaler next state.
    always_comb begin
        next_pre_count = pre_count;
        capture_hit = 1'b0;
        if (kind_of(mode) != CCPCU_CAPTURE) begin
            next_pre_count = 5'h00;
        end else begin
            unique case (mode)
                4'h4: capture_hit = pin_fall;
                4'h5: capture_hit = pin_rise;
                4'h6: begin
                    // Count is kept across prescaler changes.
                    if (pin_rise) begin
                        if (pre_count + 5'h01 >= `CCPCU_PRE_4) begin
                            capture_hit = 1'b1;
                            next_pre_count = 5'h00;
                        end else begin
                            next_pre_count = pre_count + 5'h01;
                        end
                    end
                end
                default: begin
                    if (pin_rise) begin
                        if (pre_count + 5'h01 >= `CCPCU_PRE_16) begin
                            capture_hit = 1'b1;
                            next_pre_count = 5'h00;
                        end else begin
                            next_pre_count = pre_count + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Register, flag and compare action next state.
    always_comb begin
        next_control = unit_control;
        next_value = capture_value;
        next_pin_select = pin_select;
        next_flag = event_flag;
        next_compare_out = compare_out;
        next_trigger = 1'b0;
        next_timer_reset = 1'b0;
        next_adc = 1'b0;
        next_prdata = 32'h0000_0000;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        // Software writes, including the flag clear.
        if (access_wr) begin
            unique case (paddr)
                `CCPCU_OFF_CONTROL:
                    next_control = pwdata[7:0] & `CCPCU_CTRL_MASK;
                `CCPCU_OFF_VAL_LOW: next_value[7:0] = pwdata[7:0];
                `CCPCU_OFF_VAL_HIGH: next_value[TW-1:8] = pwdata[TW-9:0];
                `CCPCU_OFF_FLAG: begin
                    if (pwdata[0] == 1'b0) begin
                        next_flag = 1'b0;
                    end
                end
                `CCPCU_OFF_PINSEL: next_pin_select = pwdata[0];
                default: next_pslverr = 1'b0;
            endcase
        end
        // Clearing control forces the compare latch low; a same-cycle match in mode 2, 8 or A overrides it.
        if (mode_write && pwdata[3:0] == 4'h0) begin
            next_compare_out = 1'b0;
        end
        // A capture overwrites the stored pair; set beats a clear.
        if (capture_hit) begin
            next_value = companion_timer_count;
            next_flag = 1'b1;
        end
        // A mode write may leave a spurious edge; that flag is tolerated.
        if (timer_match && kind_of(mode) == CCPCU_COMPARE) begin
            next_flag = 1'b1;
            unique case (mode)
                4'h2: next_compare_out = ~compare_out;
                4'h8: next_compare_out = 1'b1;
                4'h9: next_compare_out = 1'b0;
                4'hB: begin
                    next_trigger = 1'b1;
                    next_timer_reset = 1'b1;
                    next_adc = IS_SECOND_UNIT;
                end
                default: next_compare_out = compare_out;
            endcase
        end
        // Reads: unmapped addresses return zero without error.
        if (access_rd) begin
            unique case (paddr)
                `CCPCU_OFF_CONTROL: next_prdata = {24'h000000, unit_control};
                `CCPCU_OFF_VAL_LOW: next_prdata[7:0] = capture_value[7:0];
                `CCPCU_OFF_VAL_HIGH:
                    next_prdata[TW-9:0] = capture_value[TW-1:8];
                `CCPCU_OFF_FLAG: next_prdata[0] = event_flag;
                `CCPCU_OFF_PINSEL: next_prdata[0] = pin_select;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        next_pready = setup;
    end

    // Register all state; reset clears everything including prescaler.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_control <= `CCPCU_CTRL_RESET;
            capture_value <= `CCPCU_VAL_RESET;
            pin_select <= 1'b0;
            pre_count <= 5'h00;
            event_flag <= 1'b0;
            compare_out <= 1'b0;
            special_trigger <= 1'b0;
            timer_reset_req <= 1'b0;
            adc_start <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pwm_duty <= 10'h000;
        end else begin
            unit_control <= next_control;
            capture_value <= next_value;
            pin_select <= next_pin_select;
            pre_count <= next_pre_count;
            event_flag <= next_flag;
            compare_out <= next_compare_out;
            special_trigger <= next_trigger;
            // Timer clears on its next edge, one cycle after the trigger.
            timer_reset_req <= special_trigger;
            adc_start <= next_adc;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            // Duty: high eight from the low value byte, low two from control.
            pwm_duty <= {capture_value[7:0],
                unit_control[`CCPCU_DUTY_MSB:`CCPCU_DUTY_LSB]};
        end
    end

    // A capture loads the timer count and raises the flag next cycle.
    chk_capture_load: assert property (@(posedge pclk) disable iff (!presetn)
        capture_hit |=> capture_value == $past(companion_timer_count)
            && event_flag)
        else $error("capture did not load count and flag");
    chk_capture_flag: assert property (@(posedge pclk) disable iff (!presetn)
        capture_hit && access_wr && paddr == `CCPCU_OFF_FLAG |=> event_flag)
        else $error("capture lost against flag clear");
    chk_pre_idle: assert property (@(posedge pclk) disable iff (!presetn)
        kind_of(mode) != CCPCU_CAPTURE |=> pre_count == 5'h00)
        else $error("prescaler not held clear");
    chk_pre_bound: assert property (@(posedge pclk) disable iff (!presetn)
        pre_count < `CCPCU_PRE_16)
        else $error("prescaler count out of range");
    chk_rise_mode: assert property (@(posedge pclk) disable iff (!presetn)
        mode == 4'h5 && pin_rise |-> capture_hit)
        else $error("rising edge missed in every-edge mode");
    chk_fall_only: assert property (@(posedge pclk) disable iff (!presetn)
        mode == 4'h4 && !pin_fall |-> !capture_hit)
        else $error("capture without falling edge");
    chk_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == 4'h0 || mode == 4'h1 || mode == 4'h3) |-> !capture_hit)
        else $error("capture in off or reserved mode");
    chk_trig_reset: assert property (@(posedge pclk) disable iff (!presetn)
        special_trigger |=> timer_reset_req)
        else $error("timer reset did not follow trigger");
    chk_adc_unit: assert property (@(posedge pclk) disable iff (!presetn)
        adc_start |-> IS_SECOND_UNIT && special_trigger)
        else $error("conversion start from wrong unit");
    chk_duty_bits: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 pwm_duty[1:0] == $past(unit_control[5:4]))
        else $error("duty low bits mismatch");
    chk_cmp_flag: assert property (@(posedge pclk) disable iff (!presetn)
        timer_match && kind_of(mode) == CCPCU_COMPARE |=> event_flag)
        else $error("compare match did not set flag");
    chk_overwrite: assert property (@(posedge pclk) disable iff (!presetn)
        capture_hit && event_flag |=>
            capture_value == $past(companion_timer_count))
        else $error("second capture did not overwrite");
endmodule
`default_nettype wire

// >>> test/ccpcu_pin_model.sv
// Partner model: the external event source on the two capture pins.
`timescale 1ns/1ps
`default_nettype none
module ccpcu_pin_model (
    // Clock.
    input wire logic pclk,
    // Wanted level, pin choice and late answer.
    input wire logic lvl_req,
    input wire logic use_b,
    input wire logic slow,
    // Levels on the two alternative pins.
    output logic pin_c,
    output logic pin_b
);
    // Delay line, so an edge lands promptly or several cycles late.
    logic [3:0] dly = 4'h0;
    // Both pins idle low until an event is asked for.
    initial begin
        pin_c = 1'b0;
        pin_b = 1'b0;
    end
    // Only the chosen pin moves; the other keeps its last level.
    always @(posedge pclk) begin
        dly <= {dly[2:0], lvl_req};
        if (use_b) begin
            pin_b <= slow ? dly[3] : dly[0];
        end else begin
            pin_c <= slow ? dly[3] : dly[0];
        end
    end
endmodule
`default_nettype wire

// >>> test/test_ccp_capture_unit.sv
// Self-checking bench for the capture unit against a behavioural model.
`timescale 1ns/1ps
`default_nettype none
`include "ccpcu_params.svh"
module test_ccp_capture_unit;
    import ccpcu_pkg::*;
    // Clock, reset and APB master signals.
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Pin model controls and the companion timer, same clock.
    logic pin_c, pin_b;
    logic lvl_req = 1'b0;
    logic use_b = 1'b0;
    logic slow = 1'b0;
    logic [15:0] tcount = 16'h0000;
    logic tmatch = 1'b0;
    // Outputs of the unit.
    logic compare_out, special_trigger, timer_reset_req, adc_start;
    logic event_flag;
    logic [9:0] pwm_duty;
    // Model state; rd keeps the last read word.
    logic [31:0] seed = 32'h62DA7129;
    logic [31:0] rd;
    logic [15:0] m_val = 16'h0000;
    logic m_flag = 1'b0;
    logic m_cout = 1'b0;
    int m_mode = 0;
    int m_pre = 0;
    int err_total = 0;
    int n_tests = 0;
    int n_trig = 0;
    int n_adc = 0;
    int n_rst = 0;
    always #2.5 pclk = ~pclk;
    ccpcu_capture_unit #(.IS_SECOND_UNIT(1'b1), .TW(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .portc_pin_one(pin_c),
        .portb_pin_three(pin_b), .companion_timer_count(tcount),
        .timer_match(tmatch), .compare_out(compare_out),
        .special_trigger(special_trigger),
        .timer_reset_req(timer_reset_req), .adc_start(adc_start),
        .event_flag(event_flag), .pwm_duty(pwm_duty));
    ccpcu_pin_model pins (.pclk(pclk), .lvl_req(lvl_req), .use_b(use_b),
        .slow(slow), .pin_c(pin_c), .pin_b(pin_b));
    // Pulses are counted as they pass, since each stands one cycle only.
    always @(posedge pclk) begin
        n_trig += (special_trigger === 1'b1);
        n_adc += (adc_start === 1'b1);
        n_rst += (timer_reset_req === 1'b1);
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        if (k == 50) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        chk("pslverr", 32'h0, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // A mode write, then the flag is cleared as software should.
    task automatic set_mode(input logic [7:0] c);
        apb(1'b1, `CCPCU_OFF_CONTROL, {24'h0, c});
        m_mode = int'(c[3:0]);
        if (m_mode < 4 || m_mode > 7) m_pre = 0;
        if (c[3:0] == 4'h0) m_cout = 1'b0;
        apb(1'b1, `CCPCU_OFF_FLAG, 32'h0);
        m_flag = 1'b0;
    endtask
    // One pin edge with a fresh timer count, and its expected result.
    task automatic pin_edge(input logic r);
        seed = xs(seed);
        slow <= seed[0];
        tcount <= seed[31:16];
        @(posedge pclk);
        lvl_req <= r;
        repeat (14) @(posedge pclk);
        if ((m_mode == 4 && !r) || (m_mode == 5 && r)) begin
            m_pre = 16;
        end else if (r && (m_mode == 6 || m_mode == 7)) begin
            m_pre++;
        end
        if (m_pre == 16 || (m_mode == 6 && m_pre == 4)) begin
            m_val = seed[31:16];
            m_flag = 1'b1;
            m_pre = 0;
        end
        chk("event_flag", {31'h0, m_flag}, {31'h0, event_flag});
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            pin_edge(1'b1);
            pin_edge(1'b0);
        end
    endtask
    task automatic chk_val();
        apb(1'b0, `CCPCU_OFF_VAL_LOW, 32'h0);
        chk("value_low", {24'h0, m_val[7:0]}, rd);
        apb(1'b0, `CCPCU_OFF_VAL_HIGH, 32'h0);
        chk("value_high", {24'h0, m_val[15:8]}, rd);
    endtask
    initial begin
        #400000;
        err_total++;
        close_out();
    end
    initial begin
        logic [3:0] cc [5] = '{4'h2, 4'h9, 4'h8, 4'hA, 4'hB};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 24; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            chk("reset_read", 32'h0, rd);
        end
        $display("test reset done");
        for (int m = 4; m < 6; m++) begin
            set_mode(8'(m));
            pulses(2);
            chk_val();
        end
        $display("test edges done");
        set_mode(8'h06);
        pulses(3);
        set_mode(8'h00);
        set_mode(8'h06);
        pulses(4);
        chk_val();
        pulses(2);
        set_mode(8'h07);
        pulses(14);
        chk_val();
        $display("test prescaler done");
        set_mode(8'h01);
        pulses(1);
        set_mode(8'h03);
        pulses(1);
        $display("test reserved done");
        apb(1'b1, `CCPCU_OFF_PINSEL, 32'h1);
        use_b <= 1'b1;
        set_mode(8'h05);
        pulses(2);
        chk_val();
        $display("test pin select done");
        set_mode(8'hFF);
        apb(1'b0, `CCPCU_OFF_CONTROL, 32'h0);
        chk("control", 32'h3F, rd);
        chk("pwm_duty", {22'h0, m_val[7:0], 2'b11}, {22'h0, pwm_duty});
        $display("test pwm done");
        foreach (cc[i]) begin
            set_mode({4'h0, cc[i]});
            tmatch <= 1'b1;
            @(posedge pclk);
            tmatch <= 1'b0;
            repeat (4) @(posedge pclk);
            if (cc[i] == 4'h2) m_cout = ~m_cout;
            if (cc[i] == 4'h8) m_cout = 1'b1;
            if (cc[i] == 4'h9) m_cout = 1'b0;
            chk("cmp_flag", 32'h1, {31'h0, event_flag});
            chk("compare_out", {31'h0, m_cout}, {31'h0, compare_out});
        end
        chk("triggers", 32'h1, n_trig);
        chk("adc_starts", 32'h1, n_adc);
        chk("timer_resets", 32'h1, n_rst);
        set_mode(8'h00);
        chk("compare_off", 32'h0, {31'h0, compare_out});
        $display("test compare done");
        close_out();
    end
endmodule
`default_nettype wire
